/* File: rtl/sla_dev_end.sv */
// Purpose: Transmit-side framing counters with SYSREF alignment
// Assumes: clock_i is the sample clock; SYSREF synchronous to it
// Notes:   Falling-edge capture is modelled as a one cycle later sample
//          Subclass 0 ignores SYSREF; dividers free-run from reset
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Lane rate kept within 1.6875 to 15.5 Gbps
// - Rate over 40 under clock; LCM at most 64
// - PLL setting programmed from the lane rate
// - Frames times octets divisible by four, K<=32
// - Output rate is sample clock over decimation
// - Subclass bit one selects Subclass 1
// - Subclass 0 runs free, SYSREF ignored
// - SYSREF realigns multiframe clock and sample dividers
// - Receiver starts buffering on its multiframe boundary
// - Total latency variation within one multiframe
// - Multiframe clock delayed by five-bit offset
// - Offset step follows octets per frame
// - Readable SYSREF timing monitor register
// - Control bit 4 picks SYSREF transition level
// - Control bit 3 picks capture clock edge
// - Event is rising or falling SYSREF transition
// - Capture on rising or falling clock phase
module sla_dev_end import sla_pkg::*; #(
  parameter int CHIP_DECIMATION_RATIO = 8,
  parameter int S   = 1,
  parameter int K   = 32,
  parameter int F   = 2,
  parameter int SW  = 16
) (
  input  wire logic          clock_i,
  input  wire logic          rst_n_i,
  sla_link_if.dev            link,
  input  wire logic [SW-1:0] sample_i,
  output logic               sample_stb_o,
  output logic               frame_o,
  output logic               lmfc_o,
  output logic               subclass1_o
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]    sr_ctl;
    logic [7:0]    pll;
    logic [7:0]    off;
    logic [7:0]    sub;
    logic [7:0]    mon;
    logic [7:0]    rdata;
    logic          sr_a;
    logic          sr_b;
    logic          sr_prev;
    logic [6:0]    div;
    logic [4:0]    smp;
    logic [5:0]    frm;
    logic          smp_stb;
    logic          frame;
    logic          lmfc;
    logic          valid;
    logic [SW-1:0] data;
  } sla_dev_s;

  localparam sla_dev_s SLA_DEV_RST = '{
    sr_ctl: SLA_RST_SR_CTL,
    pll:    SLA_RST_PLL,
    off:    SLA_RST_OFF,
    sub:    SLA_RST_SUB,
    default: '0
  };

  sla_dev_s q;
  sla_dev_s n;

  logic       sel;
  logic       ev;
  logic       sub1;
  logic       misalign;
  logic       ev_ok;
  logic [4:0] dly;
  logic [5:0] dly_k;
  logic [5:0] frm_nxt;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n          = q;
    n.smp_stb  = 1'b0;
    n.frame    = 1'b0;
    n.lmfc     = 1'b0;
    n.valid    = 1'b0;
    n.rdata    = 8'h00;
    frm_nxt    = q.frm;

    // Register writes; only the five offset bits are kept
    if (link.wr) begin
      if (link.addr == SLA_A_SR_CTL) begin
        n.sr_ctl = link.wdata;
      end else if (link.addr == SLA_A_PLL) begin
        n.pll = link.wdata;
      end else if (link.addr == SLA_A_OFF) begin
        n.off = {3'h0, link.wdata[4:0]};
      end else if (link.addr == SLA_A_SUB) begin
        n.sub = link.wdata;
      end
    end

    // Read data stands only in the cycle after the strobe
    // Unmapped addresses read as zero
    if (link.rd) begin
      if (link.addr == SLA_A_SR_CTL) begin
        n.rdata = q.sr_ctl;
      end else if (link.addr == SLA_A_SR_MON) begin
        n.rdata = q.mon;
      end else if (link.addr == SLA_A_PLL) begin
        n.rdata = q.pll;
      end else if (link.addr == SLA_A_OFF) begin
        n.rdata = q.off;
      end else if (link.addr == SLA_A_SUB) begin
        n.rdata = q.sub;
      end
    end

    // ****************************************
    // SYSREF capture
    // ****************************************
    // Second stage stands in for the opposite clock phase
    n.sr_a    = link.sysref;
    n.sr_b    = q.sr_a;
    sel       = q.sr_ctl[SLA_B_EDGE] ? q.sr_b : q.sr_a;
    n.sr_prev = sel;
    ev        = q.sr_ctl[SLA_B_TRANS] ? (q.sr_prev & ~sel) : (~q.sr_prev & sel);
    sub1      = q.sub[SLA_B_SUB1];

    // ****************************************
    // Multiframe offset
    // ****************************************
    // Offset granularity: F=1 steps of four, F=2 steps of two
    if (F == 1) begin
      dly = {q.off[4:2], 2'b00};
    end else if (F == 2) begin
      dly = {q.off[4:1], 1'b0};
    end else begin
      dly = q.off[4:0];
    end
    dly_k = 6'(int'(dly) % K);

    // Sample divider gives the output rate; frames and multiframes follow
    // The frame index that equals the delay carries the multiframe mark
    if (q.div == 7'(CHIP_DECIMATION_RATIO - 1)) begin
      n.div     = 7'h00;
      n.smp_stb = 1'b1;
      n.valid   = 1'b1;
      n.data    = sample_i;
      if (q.smp == 5'(S - 1)) begin
        n.smp   = 5'h00;
        frm_nxt = (q.frm == 6'(K - 1)) ? 6'h00 : q.frm + 6'h01;
        n.frm   = frm_nxt;
        n.frame = 1'b1;
        n.lmfc  = (frm_nxt == dly_k);
      end else begin
        n.smp = q.smp + 5'h01;
      end
    end else begin
      n.div = q.div + 7'h01;
    end

    // ****************************************
    // Alignment
    // ****************************************
    // Alignment event restarts dividers at the start of a multiframe.
    // In Subclass 0 events are dropped so a floating SYSREF does no harm.
    misalign = (q.div != 7'h00) || (q.smp != 5'h00) || (q.frm != 6'h00);
    ev_ok    = sub1 && ev;
    if (ev_ok) begin
      n.div     = 7'h00;
      n.smp     = 5'h00;
      n.frm     = 6'h00;
      n.frame   = 1'b1;
      n.lmfc    = (dly_k == 6'h00);
      n.mon     = {1'b1, misalign, q.frm};
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      q <= SLA_DEV_RST;
    end else begin
      q <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.rdata   = q.rdata;
  assign link.frame   = q.frame;
  assign link.lmfc    = q.lmfc;
  assign link.valid   = q.valid;
  assign link.data    = q.data;
  assign sample_stb_o = q.smp_stb;
  assign frame_o      = q.frame;
  assign lmfc_o       = q.lmfc;
  assign subclass1_o  = q.sub[SLA_B_SUB1];
endmodule // sla_dev_end
`default_nettype wire

/* File: rtl/sla_host_end.sv */
// Purpose: Receiver-side controller: configures the device, issues
//          SYSREF, keeps its own multiframe clock and releases buffering
// Assumes: Same sample clock as the device end
// Notes:   Configuration checks are elaboration-time constants
`timescale 1ns/10ps
`default_nettype none
module sla_host_end import sla_pkg::*; #(
  parameter int     CHIP_DECIMATION_RATIO      = 8,
  parameter int     S        = 1,
  parameter int     K        = 32,
  parameter int     F        = 2,
  parameter int     M        = 4,
  parameter int     NP       = 16,
  parameter int     L        = 4,
  parameter longint FCLK_KHZ = 2949120,
  parameter int     SW       = 16
) (
  input  wire logic          clock_i,
  input  wire logic          rst_n_i,
  sla_link_if.rcv            link,
  input  wire logic [3:0]    addr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic [7:0]         rdata_o,
  output logic               buf_start_o,
  output logic               rx_valid_o,
  output logic [SW-1:0]      rx_data_o
);
  localparam longint     SERIAL_LANE_RATE    = sla_lane_rate(M, NP, L, FCLK_KHZ, CHIP_DECIMATION_RATIO);
  localparam logic [7:0] PLLV   = sla_pll_value(SERIAL_LANE_RATE);
  localparam bit         CFG_OK = sla_cfg_ok(SERIAL_LANE_RATE, FCLK_KHZ, CHIP_DECIMATION_RATIO, F, K);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    sla_state_e    st;
    logic [7:0]    ctl;
    logic [7:0]    off;
    logic [15:0]   adr;
    logic [7:0]    wd;
    logic [7:0]    drd;
    logic [7:0]    rdata;
    logic [15:0]   ba;
    logic [7:0]    bwd;
    logic          bwr;
    logic          brd;
    logic          rdp;
    logic          sr;
    logic [1:0]    srn;
    logic [6:0]    div;
    logic [4:0]    smp;
    logic [5:0]    frm;
    logic [5:0]    ph;
    logic          phv;
    logic          lat_err;
    logic          started;
    logic          bstart;
    logic          rxv;
    logic [SW-1:0] rxd;
  } sla_host_s;

  localparam sla_host_s SLA_HOST_RST = '{st: SLA_IDLE, ctl: SLA_RST_CTL, default: '0};

  sla_host_s q;
  sla_host_s n;
  logic      hl;
  logic      busy;

  always_comb begin
    n        = q;
    n.bwr    = 1'b0;
    n.brd    = 1'b0;
    n.bstart = 1'b0;
    n.rdata  = 8'h00;
    n.rdp    = q.brd;
    busy     = (q.st != SLA_IDLE) && (q.st != SLA_RUN);
    if (q.rdp) begin
      n.drd = link.rdata;
    end

    // Own multiframe clock, restarted when SYSREF is issued
    hl    = (q.div == 7'(CHIP_DECIMATION_RATIO - 1)) && (q.smp == 5'(S - 1)) && (q.frm == 6'(K - 1));
    n.div = (q.div == 7'(CHIP_DECIMATION_RATIO - 1)) ? 7'h00 : q.div + 7'h01;
    if (q.div == 7'(CHIP_DECIMATION_RATIO - 1)) begin
      n.smp = (q.smp == 5'(S - 1)) ? 5'h00 : q.smp + 5'h01;
      if (q.smp == 5'(S - 1)) begin
        n.frm = (q.frm == 6'(K - 1)) ? 6'h00 : q.frm + 6'h01;
      end
    end

    // Software port
    if (rd_i) begin
      if (addr_i == SLA_H_CTL) begin
        n.rdata = q.ctl;
      end else if (addr_i == SLA_H_STAT) begin
        n.rdata = {3'h0, busy, q.lat_err, q.started, q.phv, CFG_OK};
      end else if (addr_i == SLA_H_ADL) begin
        n.rdata = q.adr[7:0];
      end else if (addr_i == SLA_H_ADH) begin
        n.rdata = q.adr[15:8];
      end else if (addr_i == SLA_H_WD) begin
        n.rdata = q.wd;
      end else if (addr_i == SLA_H_RD) begin
        n.rdata = q.drd;
      end else if (addr_i == SLA_H_PH) begin
        n.rdata = {2'h0, q.ph};
      end else if (addr_i == SLA_H_OFF) begin
        n.rdata = q.off;
      end
    end
    if (wr_i) begin
      if (addr_i == SLA_H_CTL) begin
        n.ctl = {6'h00, wdata_i[1], 1'b0};
      end else if (addr_i == SLA_H_STAT && wdata_i[3]) begin
        n.lat_err = 1'b0;
      end else if (addr_i == SLA_H_ADL) begin
        n.adr[7:0] = wdata_i;
      end else if (addr_i == SLA_H_ADH) begin
        n.adr[15:8] = wdata_i;
      end else if (addr_i == SLA_H_WD) begin
        n.wd = wdata_i;
      end else if (addr_i == SLA_H_CMD && !busy) begin
        n.ba  = q.adr;
        n.bwd = q.wd;
        n.bwr = wdata_i[0];
        n.brd = wdata_i[1] & ~wdata_i[0];
      end else if (addr_i == SLA_H_OFF) begin
        n.off = {3'h0, wdata_i[4:0]};
      end
    end

    // Arrival phase of the device multiframe marker; a set beats a clear
    if (link.lmfc && q.st == SLA_RUN) begin
      n.ph  = q.frm;
      n.phv = 1'b1;
      if (q.phv && q.ph != q.frm) begin
        n.lat_err = 1'b1;
      end
    end
    if (q.phv && !q.started && hl) begin
      n.bstart  = 1'b1;
      n.started = 1'b1;
    end
    n.rxv = link.valid & q.started;
    n.rxd = link.data;

    // Configuration sequence
    case (q.st)
      SLA_IDLE: begin
        if (wr_i && addr_i == SLA_H_CTL && wdata_i[0] && CFG_OK) begin
          n.bwr     = 1'b1;
          n.ba      = SLA_A_PLL;
          n.bwd     = PLLV;
          n.started = 1'b0;
          n.phv     = 1'b0;
          n.st      = SLA_PLL;
        end
      end
      SLA_PLL: begin
        n.bwr = 1'b1;
        n.ba  = SLA_A_SUB;
        n.bwd = 8'(q.ctl[1]) << SLA_B_SUB1;
        n.st  = SLA_SUB;
      end
      SLA_SUB: begin
        n.bwr = 1'b1;
        n.ba  = SLA_A_OFF;
        n.bwd = q.off;
        n.st  = SLA_OFFW;
      end
      SLA_OFFW: begin
        if (q.ctl[1]) begin
          n.sr  = 1'b1;
          n.srn = 2'(SLA_SR_CYC - 1);
          n.div = 7'h00;
          n.smp = 5'h00;
          n.frm = 6'h00;
          n.st  = SLA_SYNC;
        end else begin
          n.phv = 1'b1;
          n.st  = SLA_RUN;
        end
      end
      SLA_SYNC: begin
        if (q.srn == 2'h0) begin
          n.sr = 1'b0;
          n.st = SLA_RUN;
        end else begin
          n.srn = q.srn - 2'h1;
        end
      end
      SLA_RUN: begin
        if (wr_i && addr_i == SLA_H_CTL && wdata_i[0]) begin
          n.st = SLA_IDLE;
        end
      end
      default: n.st = SLA_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      q <= SLA_HOST_RST;
    end else begin
      q <= n;
    end
  end

  assign link.addr   = q.ba;
  assign link.wdata  = q.bwd;
  assign link.wr     = q.bwr;
  assign link.rd     = q.brd;
  assign link.sysref = q.sr;
  assign rdata_o     = q.rdata;
  assign buf_start_o = q.bstart;
  assign rx_valid_o  = q.rxv;
  assign rx_data_o   = q.rxd;
endmodule // sla_host_end
`default_nettype wire

/* File: rtl/sla_link_if.sv */
// Purpose: Carrier between the device end and the host end
// Assumes: Both ends on the same sample clock
// Notes:   Register port plus SYSREF and multiframe markers
`timescale 1ns/10ps
`default_nettype none
interface sla_link_if #(parameter int SW = 16);
  logic [15:0]   addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  logic          wr;
  logic          rd;
  logic          sysref;
  logic          frame;
  logic          lmfc;
  logic          valid;
  logic [SW-1:0] data;
  modport dev (input addr, wdata, wr, rd, sysref, output rdata, frame, lmfc, valid, data);
  modport rcv (output addr, wdata, wr, rd, sysref, input rdata, frame, lmfc, valid, data);
endinterface
`default_nettype wire

/* File: rtl/sla_pkg.sv */
// Purpose: Shared constants for the lane alignment device and host ends
// Assumes: One sample clock domain; rates held in kHz and kbps
// Notes:   Register offsets are the device map seen by the host
package sla_pkg;
  // ****************************************
  // Device register map
  // ****************************************
  localparam logic [15:0] SLA_A_SR_CTL = 16'h0120;
  localparam logic [15:0] SLA_A_SR_MON = 16'h0128;
  localparam logic [15:0] SLA_A_PLL    = 16'h056e;
  localparam logic [15:0] SLA_A_OFF    = 16'h0578;
  localparam logic [15:0] SLA_A_SUB    = 16'h0590;
  localparam logic [7:0]  SLA_RST_SR_CTL = 8'h00;
  localparam logic [7:0]  SLA_RST_PLL    = 8'h00;
  localparam logic [7:0]  SLA_RST_OFF    = 8'h00;
  localparam logic [7:0]  SLA_RST_SUB    = 8'h20;
  localparam int          SLA_B_EDGE  = 3;
  localparam int          SLA_B_TRANS = 4;
  localparam int          SLA_B_SUB1  = 5;
  // ****************************************
  // Lane rate limits and PLL settings
  // ****************************************
  localparam logic [7:0]  SLA_PLL_HI  = 8'h30;
  localparam logic [7:0]  SLA_PLL_MID = 8'h10;
  localparam logic [7:0]  SLA_PLL_LOW = 8'h00;
  localparam logic [7:0]  SLA_PLL_MIN = 8'h50;
  localparam longint      SLA_SLR_MAX = 15500000;
  localparam longint      SLA_SLR_HI  = 13500000;
  localparam longint      SLA_SLR_MID = 6750000;
  localparam longint      SLA_SLR_LOW = 3375000;
  localparam longint      SLA_SLR_MIN = 1687500;
  localparam int          SLA_SLR_DIV = 40;
  localparam int          SLA_LCM_FAC = 20;
  localparam int          SLA_LCM_MAX = 64;
  localparam int          SLA_KF_MULT = 4;
  localparam int          SLA_K_MAX   = 32;
  localparam int          SLA_SR_CYC  = 2;
  // ****************************************
  // Host register map
  // ****************************************
  localparam logic [3:0]  SLA_H_CTL  = 4'h0;
  localparam logic [3:0]  SLA_H_STAT = 4'h1;
  localparam logic [3:0]  SLA_H_ADL  = 4'h2;
  localparam logic [3:0]  SLA_H_ADH  = 4'h3;
  localparam logic [3:0]  SLA_H_WD   = 4'h4;
  localparam logic [3:0]  SLA_H_CMD  = 4'h5;
  localparam logic [3:0]  SLA_H_RD   = 4'h6;
  localparam logic [3:0]  SLA_H_PH   = 4'h7;
  localparam logic [3:0]  SLA_H_OFF  = 4'h8;
  localparam logic [7:0]  SLA_RST_CTL = 8'h02;

  typedef enum logic [5:0] {
    SLA_IDLE = 6'h01, SLA_PLL = 6'h02, SLA_SUB = 6'h04,
    SLA_OFFW = 6'h08, SLA_SYNC = 6'h10, SLA_RUN = 6'h20
  } sla_state_e;

  function automatic longint sla_lane_rate(int m, int np, int l, longint fclk, int chip_decimation_ratio);
    longint output_sample_rate;
    output_sample_rate = fclk / chip_decimation_ratio;
    return (m * np * 10 * output_sample_rate) / (8 * l);
  endfunction

  function automatic logic [7:0] sla_pll_value(longint serial_lane_rate);
    if (serial_lane_rate > SLA_SLR_HI) return SLA_PLL_HI;
    else if (serial_lane_rate >= SLA_SLR_MID) return SLA_PLL_MID;
    else if (serial_lane_rate >= SLA_SLR_LOW) return SLA_PLL_LOW;
    else return SLA_PLL_MIN;
  endfunction

  function automatic int sla_gcd(int a, int b);
    int t;
    while (b != 0) begin
      t = a % b;
      a = b;
      b = t;
    end
    return a;
  endfunction

  function automatic bit sla_cfg_ok(longint serial_lane_rate, longint fclk, int chip_decimation_ratio, int f, int k);
    int r;
    int lcm;
    int kmin;
    r    = int'((SLA_LCM_FAC * chip_decimation_ratio * (fclk / chip_decimation_ratio)) / serial_lane_rate);
    lcm  = (r == 0) ? chip_decimation_ratio : (r * chip_decimation_ratio) / sla_gcd(r, chip_decimation_ratio);
    kmin = (f == 1) ? 20 : (f == 2) ? 12 : (f == 4) ? 8 : 4;
    return serial_lane_rate >= SLA_SLR_MIN && serial_lane_rate <= SLA_SLR_MAX && serial_lane_rate / SLA_SLR_DIV <= fclk
        && lcm <= SLA_LCM_MAX && (f * k) % SLA_KF_MULT == 0 && k <= SLA_K_MAX
        && k >= kmin;
  endfunction
endpackage

/* File: tb/serdes_link_latency_align_bench.sv */
// Purpose: Self-checking bench joining device end and host end
// Assumes: Default parameters, F = 2, lane rate 7.3728 Gbps
// Notes:   Device registers are reached through the host command port
`timescale 1ns/10ps
`default_nettype none
module serdes_link_latency_align_bench import sla_pkg::*;;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        rd_d = 1'b0;
  logic        buf_seen = 1'b0;
  logic        running = 1'b0;
  logic        stb_d = 1'b0;
  logic [15:0] sample_i = 16'h0000;
  logic [15:0] smp_d1 = 16'h0000;
  logic [15:0] smp_d2 = 16'h0000;
  logic [31:0] seed_r = 32'd60580;
  logic [7:0]  rdata_o;
  logic [15:0] rx_data_o;
  logic        frame_o, lmfc_o, subclass1_o, buf_start_o, rx_valid_o, sample_stb_o;
  logic [7:0]  exp_q[$];
  logic [7:0]  msk_q[$];
  int          n_fail = 0;
  int          n_compared = 0;
  localparam logic [15:0] RA[5] = '{SLA_A_SR_CTL, SLA_A_PLL, SLA_A_OFF, SLA_A_SUB, 16'h0121};
  localparam logic [7:0]  RV[5] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h00};
  localparam logic [7:0]  OF[3] = '{8'h26, 8'h03, 8'h11};
  localparam logic [7:0]  PH[3] = '{8'h06, 8'h02, 8'h10};
  always #12.5 clock_i = ~clock_i;
  sla_link_if sla_link_if_i ();
  sla_dev_end sla_dev_end_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .link(sla_link_if_i), .sample_i(sample_i), .sample_stb_o(sample_stb_o),
    .frame_o(frame_o), .lmfc_o(lmfc_o), .subclass1_o(subclass1_o));
  sla_host_end sla_host_end_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .link(sla_link_if_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .buf_start_o(buf_start_o), .rx_valid_o(rx_valid_o),
    .rx_data_o(rx_data_o));
  sla_link_chk #(.CHIP_DECIMATION_RATIO(8), .S(1), .K(32), .SW(16)) sla_link_chk_i (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .addr(sla_link_if_i.addr), .wdata(sla_link_if_i.wdata),
    .rdata(sla_link_if_i.rdata), .wr(sla_link_if_i.wr), .rd(sla_link_if_i.rd),
    .sysref(sla_link_if_i.sysref), .frame(sla_link_if_i.frame), .lmfc(sla_link_if_i.lmfc),
    .valid(sla_link_if_i.valid), .data(sla_link_if_i.data));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    n_compared++;
    if ((got & m) !== (exp & m)) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask
  task automatic hr(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
  endtask
  task automatic dacc(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
    hw(SLA_H_ADL, a[7:0]);
    hw(SLA_H_ADH, a[15:8]);
    hw(SLA_H_WD, d);
    hw(SLA_H_CMD, c);
    repeat (4) @(posedge clock_i);
  endtask
  task automatic dr(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
    dacc(a, 8'h00, 8'h02);
    hr(SLA_H_RD, e, m);
  endtask
  task automatic start(input logic sc1);
    int n;
    // A start write while running only returns the host to idle
    if (running) hw(SLA_H_CTL, {6'h00, sc1, 1'b1});
    hw(SLA_H_CTL, {6'h00, sc1, 1'b1});
    running = 1'b1;
    n = 0;
    @(negedge clock_i);
    while (buf_start_o !== 1'b1 && n < 3000) begin
      @(negedge clock_i);
      n++;
    end
    chk({7'h00, n < 3000}, 8'h01, 8'hff);
    repeat (8) @(posedge clock_i);
  endtask
  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ****************************************
  // Stimulus and result watchers
  // ****************************************
  always @(posedge clock_i) begin
    seed_r   <= xs(seed_r);
    sample_i <= seed_r[15:0];
    smp_d1   <= sample_i;
    smp_d2   <= smp_d1;
    stb_d    <= sample_stb_o;
  end
  // Oldest note is matched against the read answer one cycle after the strobe
  always @(posedge clock_i) begin
    if (rd_d) chk(rdata_o, exp_q.pop_front(), msk_q.pop_front());
    rd_d <= rd_i;
  end
  always @(negedge clock_i) begin
    if (buf_start_o === 1'b1) buf_seen = 1'b1;
    if (rx_valid_o === 1'b1 && !buf_seen) chk(8'h01, 8'h00, 8'hff);
    if (rx_valid_o === 1'b1) begin
      chk(rx_data_o[7:0], smp_d2[7:0], 8'hff);
      chk(rx_data_o[15:8], smp_d2[15:8], 8'hff);
      chk({7'h00, stb_d}, 8'h01, 8'hff);
    end
  end
  initial begin
    repeat (40000) @(posedge clock_i);
    n_fail++;
    $display("wrong value at %0t: watchdog expired", $time);
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    hr(SLA_H_CTL, SLA_RST_CTL, 8'hff);
    for (int i = 0; i < 5; i++) dr(RA[i], RV[i], 8'hff);
    hr(4'h9 + {1'b0, seed_r[2:0] % 3'd7}, 8'h00, 8'hff);
    chk({7'h00, subclass1_o}, 8'h01, 8'hff);
    start(1'b1);
    dr(SLA_A_PLL, SLA_PLL_MID, 8'hff);
    hr(SLA_H_STAT, 8'h07, 8'h07);
    repeat (600) @(posedge clock_i);
    for (int m = 0; m < 4; m++) begin
      dacc(SLA_A_SR_CTL, 8'(m << 3), 8'h01);
      dr(SLA_A_SR_CTL, 8'(m << 3), 8'hff);
      start(1'b1);
      dr(SLA_A_SR_MON, 8'h80, 8'h80);
    end
    for (int i = 0; i < 3; i++) begin
      hw(SLA_H_OFF, OF[i]);
      start(1'b1);
      hw(SLA_H_STAT, 8'h08);
      hr(SLA_H_PH, PH[i], 8'h1f);
      dr(SLA_A_OFF, OF[i] & 8'h1f, 8'hff);
      repeat (600) @(posedge clock_i);
      hr(SLA_H_STAT, 8'h00, 8'h08);
    end
    start(1'b0);
    dr(SLA_A_SUB, 8'h00, 8'hff);
    chk({7'h00, subclass1_o}, 8'h00, 8'hff);
    repeat (300) @(posedge clock_i);
    give_verdict();
  end
endmodule // serdes_link_latency_align_bench
`default_nettype wire

/* File: tb/sla_link_chk.sv */
// Purpose: Assertions on the link between the device end and the host end
// Assumes: One sample clock; shadows follow device register writes
// Notes:   Spacing checks restart after any write or SYSREF
`timescale 1ns/10ps
`default_nettype none
module sla_link_chk import sla_pkg::*; #(
  parameter int CHIP_DECIMATION_RATIO = 8,
  parameter int S   = 1,
  parameter int K   = 32,
  parameter int SW  = 16
) (
  input wire logic          clock_i,
  input wire logic          rst_n_i,
  input wire logic [15:0]   addr,
  input wire logic [7:0]    wdata,
  input wire logic [7:0]    rdata,
  input wire logic          wr,
  input wire logic          rd,
  input wire logic          sysref,
  input wire logic          frame,
  input wire logic          lmfc,
  input wire logic          valid,
  input wire logic [SW-1:0] data
);
  localparam int FRM = CHIP_DECIMATION_RATIO * S;
  localparam int MF  = FRM * K;
  logic [7:0]  ctl_r;
  logic        sub_r;
  logic [4:0]  off_r;
  logic        ev_r;
  logic [2:0]  seen_r;
  logic [15:0] fcnt_r;
  logic [15:0] lcnt_r;
  logic [15:0] vcnt_r;
  logic [15:0] calm_r;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ****************************************
  // Shadows and spacing counters
  // ****************************************
  // Pulses right after a disturbance are not trusted as a spacing origin
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctl_r  <= SLA_RST_SR_CTL;
      sub_r  <= SLA_RST_SUB[SLA_B_SUB1];
      off_r  <= 5'h00;
      ev_r   <= 1'b0;
      seen_r <= 3'h0;
      calm_r <= 16'h0000;
    end else begin
      if (wr && addr == SLA_A_SR_CTL) ctl_r <= wdata;
      if (wr && addr == SLA_A_SUB) sub_r <= wdata[SLA_B_SUB1];
      if (wr && addr == SLA_A_OFF) off_r <= wdata[4:0];
      if (sysref && sub_r) ev_r <= 1'b1;
      if (wr || sysref) begin
        calm_r <= 16'h0000;
        seen_r <= 3'h0;
      end else begin
        calm_r <= calm_r + {15'h0000, calm_r != 16'hffff};
        if (calm_r > 16'h0008) seen_r <= seen_r | {lmfc, frame, valid};
      end
    end
    fcnt_r <= frame ? 16'h0000 : fcnt_r + 16'h0001;
    lcnt_r <= lmfc ? 16'h0000 : lcnt_r + 16'h0001;
    vcnt_r <= valid ? 16'h0000 : vcnt_r + 16'h0001;
  end
  // ****************************************
  // Properties
  // ****************************************
  sequence s_evt_a;
    sub_r && !ctl_r[SLA_B_EDGE] && (ctl_r[SLA_B_TRANS] ? $fell(sysref) : $rose(sysref));
  endsequence
  sequence s_evt_b;
    sub_r && ctl_r[SLA_B_EDGE] && (ctl_r[SLA_B_TRANS] ? $fell(sysref) : $rose(sysref));
  endsequence
  property p_align_a;  s_evt_a |-> ##[2:4] frame; endproperty
  property p_align_b;  s_evt_b |-> ##[3:5] frame; endproperty
  property p_sr_pulse; $rose(sysref) |=> sysref ##1 !sysref; endproperty
  property p_frm_per;  frame && seen_r[1] |-> fcnt_r == FRM - 1; endproperty
  property p_mf_per;   lmfc && seen_r[2] |-> lcnt_r == MF - 1; endproperty
  property p_smp_per;  valid && seen_r[0] |-> vcnt_r == CHIP_DECIMATION_RATIO - 1; endproperty
  property p_mf_frm;   lmfc |-> frame; endproperty
  property p_data;     $changed(data) |-> valid; endproperty
  property p_rd_idle;  !rd |=> rdata == 8'h00; endproperty
  property p_sub_rd;   rd && addr == SLA_A_SUB |=> rdata[SLA_B_SUB1] == $past(sub_r); endproperty
  property p_off_rd;   rd && addr == SLA_A_OFF |=> rdata == {3'h0, $past(off_r)}; endproperty
  property p_mon_rd;   rd && addr == SLA_A_SR_MON && ev_r |=> rdata[7]; endproperty
  a_align_a:  assert property (p_align_a)  else $error("frame not realigned after event");
  a_align_b:  assert property (p_align_b)  else $error("late capture not realigned");
  a_sr_pulse: assert property (p_sr_pulse) else $error("alignment pulse not two cycles");
  a_frm_per:  assert property (p_frm_per)  else $error("frame spacing wrong");
  a_mf_per:   assert property (p_mf_per)   else $error("multiframe spacing wrong");
  a_smp_per:  assert property (p_smp_per)  else $error("sample spacing wrong");
  a_mf_frm:   assert property (p_mf_frm)   else $error("multiframe mark off a frame");
  a_data:     assert property (p_data)     else $error("data moved without valid");
  a_rd_idle:  assert property (p_rd_idle)  else $error("read data not zero when idle");
  a_sub_rd:   assert property (p_sub_rd)   else $error("subclass bit readback wrong");
  a_off_rd:   assert property (p_off_rd)   else $error("offset readback wrong");
  a_mon_rd:   assert property (p_mon_rd)   else $error("monitor misses event");
endmodule // sla_link_chk
`default_nettype wire
